// ===== rtl/general_timer.sv
// two 16-bit counter halves joined as 32-bit timer or real-time clock
// assumes control writes are one-cycle strobes on ref_clk and the
// debug halt level comes from logic on ref_clk; capture_pin_0 is async
`timescale 1ns/1ps

// Overview of operation
// - two 16-bit halves, joinable as 32-bit
// - reset leaves block idle, controls cleared
// - reset sets counters and loads to ffff
// - reset clears both prescale registers
// - config 0 timer, 1 clock; 32-bit only
// - config 4 selects split 16-bit mode
// - 32-bit load write fills both halves
// - 32-bit count read gives second:first halves
// - first mode field picks one-shot/periodic
// - enable starts decrement from preloaded value
// - at zero reload load value next cycle
// - one-shot stops, clears enable; periodic continues
// - zero sets timeout flag, pulses trigger
// - unmasked timeout sets masked flag
// - load rewrite while running restarts from it
// - stall bit freezes counter during debug halt
// - clock mode counts up, first load one
// - divide input to 1 Hz count tick
// - match rolls count to zero, continues
// - match sets clock flag, interrupt if unmasked
// - clock clear bit clears clock flags
// - clock enable bit overrides both stalls
module general_timer #(
  parameter int RTC_DIV = timer_pkg::RTC_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // pins and debug
  input wire logic capture_pin_0,
  input wire logic debug_halt,
  // configuration select
  input wire logic cfg_wr,
  input wire logic [timer_pkg::CFG_W-1:0] cfg_wdata,
  // first half mode field
  input wire logic mode_wr,
  input wire logic [timer_pkg::MODE_W-1:0] mode_wdata,
  // control bits
  input wire logic ctl_wr,
  input wire logic ctl_first_enable,
  input wire logic ctl_first_stall,
  input wire logic ctl_second_stall,
  input wire logic ctl_clock_mode_enable,
  // interval loads
  input wire logic load_wr,
  input wire logic [timer_pkg::CNT_W-1:0] load_wdata,
  input wire logic second_load_wr,
  input wire logic [timer_pkg::HALF_W-1:0] second_load_wdata,
  // match
  input wire logic match_wr,
  input wire logic [timer_pkg::CNT_W-1:0] match_wdata,
  // prescale
  input wire logic first_prescale_wr,
  input wire logic second_prescale_wr,
  input wire logic [timer_pkg::PRE_W-1:0] prescale_wdata,
  // interrupt mask and clear
  input wire logic mask_wr,
  input wire logic [timer_pkg::IRQ_W-1:0] mask_wdata,
  input wire logic clear_wr,
  input wire logic [timer_pkg::IRQ_W-1:0] clear_wdata,
  // readback
  output logic [timer_pkg::CFG_W-1:0] config_select,
  output logic first_enable_bit,
  output logic [timer_pkg::CNT_W-1:0] first_count_value,
  output logic [timer_pkg::HALF_W-1:0] second_count_value,
  output logic [timer_pkg::CNT_W-1:0] first_interval_load,
  output logic [timer_pkg::HALF_W-1:0] second_interval_load,
  output logic [timer_pkg::PRE_W-1:0] first_prescale_value,
  output logic [timer_pkg::PRE_W-1:0] second_prescale_value,
  // status and events
  output logic [timer_pkg::IRQ_W-1:0] raw_irq_status,
  output logic [timer_pkg::IRQ_W-1:0] masked_irq_status,
  output logic timer_irq,
  output logic timeout_trigger
);

  localparam timer_pkg::div_t DIV_LAST = timer_pkg::div_t'(RTC_DIV - 1);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    timer_pkg::cfg_t cfg;
    timer_pkg::mode_t mode;
    logic en;
    logic stall_a;
    logic stall_b;
    logic clk_en;
    timer_pkg::half_t load_a;
    timer_pkg::half_t load_b;
    timer_pkg::half_t cnt_a;
    timer_pkg::half_t cnt_b;
    timer_pkg::pre_t pre_a;
    timer_pkg::pre_t pre_b;
    timer_pkg::word_t match;
    timer_pkg::irq_t mask;
    timer_pkg::irq_t raw;
    timer_pkg::irq_t mis;
    logic irq;
    logic trig;
    logic rtc_seen;
    timer_pkg::div_t div;
    timer_pkg::word_t count_rd;
    timer_pkg::word_t load_rd;
  } timer_s;

  localparam timer_s RESET_STATE = '{
    cfg: timer_pkg::CFG_RESET,
    mode: timer_pkg::MODE_RESET,
    en: 1'b0,
    stall_a: 1'b0,
    stall_b: 1'b0,
    clk_en: 1'b0,
    load_a: timer_pkg::HALF_RESET,
    load_b: timer_pkg::HALF_RESET,
    cnt_a: timer_pkg::HALF_RESET,
    cnt_b: timer_pkg::HALF_RESET,
    pre_a: timer_pkg::PRE_RESET,
    pre_b: timer_pkg::PRE_RESET,
    match: timer_pkg::WORD_ZERO,
    mask: timer_pkg::IRQ_NONE,
    raw: timer_pkg::IRQ_NONE,
    mis: timer_pkg::IRQ_NONE,
    irq: 1'b0,
    trig: 1'b0,
    rtc_seen: 1'b0,
    div: timer_pkg::DIV_ZERO,
    count_rd: {timer_pkg::HALF_RESET, timer_pkg::HALF_RESET},
    load_rd: {timer_pkg::HALF_RESET, timer_pkg::HALF_RESET}
  };

  timer_s st_r;
  timer_s st_nxt;

  // --------------------------------------------------------------------
  // capture pin synchroniser
  // --------------------------------------------------------------------
  logic pin_rise;

  pin_sync u_pin_sync (
    .clk(ref_clk),
    .rst(sys_rst),
    .async_in(capture_pin_0),
    .level(),
    .rise(pin_rise)
  );

  // --------------------------------------------------------------------
  // working signals
  // --------------------------------------------------------------------
  logic timer_mode;
  logic clock_mode;
  logic joined;
  logic joined_nxt;
  logic freeze;
  logic tick;
  logic count_run;
  logic pin_step;
  logic at_zero;
  logic match_hit;
  logic div_wrap;
  logic one_shot;
  logic rtc_entry;
  timer_pkg::word_t cnt;
  timer_pkg::word_t cnt_n;
  timer_pkg::word_t reload_val;
  timer_pkg::word_t cnt_down;
  timer_pkg::word_t cnt_up;
  timer_pkg::half_t load_hi;
  timer_pkg::irq_t set_bits;
  timer_pkg::irq_t clr_bits;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.trig = 1'b0;
    timer_mode = (st_r.cfg == timer_pkg::CFG_32_TIMER);
    clock_mode = (st_r.cfg == timer_pkg::CFG_32_RTC);
    joined = timer_mode | clock_mode;
    cnt = {st_r.cnt_b, st_r.cnt_a};
    cnt_n = cnt;
    set_bits = timer_pkg::IRQ_NONE;
    clr_bits = timer_pkg::IRQ_NONE;
    tick = 1'b0;
    // freeze on debug halt when a stall bit applies, unless the clock enable bit is set
    freeze = debug_halt & ~st_r.clk_en &
      (st_r.stall_a | (clock_mode & st_r.stall_b));

    // event decode
    count_run = timer_mode & st_r.en & ~freeze;
    pin_step = clock_mode & st_r.en & ~freeze & pin_rise;
    at_zero = (cnt == timer_pkg::WORD_ZERO);
    match_hit = (cnt == st_r.match);
    div_wrap = (st_r.div == DIV_LAST);
    one_shot = (st_r.mode == timer_pkg::MODE_ONE_SHOT);
    reload_val = {st_r.load_b, st_r.load_a};
    cnt_down = cnt - timer_pkg::WORD_STEP;
    cnt_up = cnt + timer_pkg::WORD_STEP;
    load_hi = load_wdata[timer_pkg::CNT_W-1:timer_pkg::HALF_W];
    rtc_entry = cfg_wr & (cfg_wdata == timer_pkg::CFG_32_RTC) &
      ~st_r.rtc_seen;

    // plain register writes
    if (cfg_wr) begin
      st_nxt.cfg = cfg_wdata;
    end
    if (mode_wr) begin
      st_nxt.mode = mode_wdata;
    end
    if (match_wr) begin
      st_nxt.match = match_wdata;
    end
    if (mask_wr) begin
      st_nxt.mask = mask_wdata;
    end
    if (first_prescale_wr) begin
      st_nxt.pre_a = prescale_wdata;
    end
    if (second_prescale_wr) begin
      st_nxt.pre_b = prescale_wdata;
    end

    // 32-bit down-counter
    if (count_run) begin
      if (at_zero) begin
        cnt_n = reload_val;
        set_bits[timer_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
        st_nxt.trig = 1'b1;
        if (one_shot) begin
          st_nxt.en = 1'b0;
        end
      end else begin
        cnt_n = cnt_down;
      end
    end

    // 32-bit real-time clock up-counter
    if (pin_step) begin
      if (div_wrap) begin
        st_nxt.div = timer_pkg::DIV_ZERO;
        tick = 1'b1;
      end else begin
        st_nxt.div = st_r.div + timer_pkg::DIV_STEP;
      end
    end
    if (tick) begin
      if (match_hit) begin
        cnt_n = timer_pkg::WORD_ZERO;
        set_bits[timer_pkg::IRQ_MATCH_BIT] = 1'b1;
      end else begin
        cnt_n = cnt_up;
      end
    end

    // interval load writes
    if (load_wr) begin
      st_nxt.load_a = load_wdata[timer_pkg::HALF_W-1:0];
      if (joined) begin
        st_nxt.load_b = load_hi;
      end
      if (timer_mode) begin
        cnt_n = load_wdata;
      end
    end
    if (second_load_wr) begin
      st_nxt.load_b = second_load_wdata;
    end

    // first entry into clock mode
    if (rtc_entry) begin
      cnt_n = timer_pkg::RTC_FIRST_LOAD;
      st_nxt.rtc_seen = 1'b1;
      st_nxt.div = timer_pkg::DIV_ZERO;
    end

    // software control write wins over the one-shot self clear
    if (ctl_wr) begin
      st_nxt.en = ctl_first_enable;
      st_nxt.stall_a = ctl_first_stall;
      st_nxt.stall_b = ctl_second_stall;
      st_nxt.clk_en = ctl_clock_mode_enable;
    end

    st_nxt.cnt_a = cnt_n[timer_pkg::HALF_W-1:0];
    st_nxt.cnt_b = cnt_n[timer_pkg::CNT_W-1:timer_pkg::HALF_W];

    // status flags, a new event wins over a clear
    if (clear_wr) begin
      clr_bits = clear_wdata;
    end
    st_nxt.raw = (st_r.raw & ~clr_bits) | set_bits;
    st_nxt.mis = st_nxt.raw & st_nxt.mask;
    st_nxt.irq = |st_nxt.mis;

    // readback views
    joined_nxt = (st_nxt.cfg == timer_pkg::CFG_32_TIMER) |
      (st_nxt.cfg == timer_pkg::CFG_32_RTC);
    if (joined_nxt) begin
      st_nxt.count_rd = {st_nxt.cnt_b, st_nxt.cnt_a};
      st_nxt.load_rd = {st_nxt.load_b, st_nxt.load_a};
    end else begin
      st_nxt.count_rd = {timer_pkg::HALF_ZERO, st_nxt.cnt_a};
      st_nxt.load_rd = {timer_pkg::HALF_ZERO, st_nxt.load_a};
    end
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign config_select = st_r.cfg;
  assign first_enable_bit = st_r.en;
  assign first_count_value = st_r.count_rd;
  assign second_count_value = st_r.cnt_b;
  assign first_interval_load = st_r.load_rd;
  assign second_interval_load = st_r.load_b;
  assign first_prescale_value = st_r.pre_a;
  assign second_prescale_value = st_r.pre_b;
  assign raw_irq_status = st_r.raw;
  assign masked_irq_status = st_r.mis;
  assign timer_irq = st_r.irq;
  assign timeout_trigger = st_r.trig;

endmodule // general_timer

// ===== rtl/pin_sync.sv
// two-flop synchroniser with registered rising-edge pulse
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin side
  input wire logic async_in,
  // synchronised side
  output logic level,
  output logic rise
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.rise = st_r.s2 & ~st_r.s3;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.s3;
  assign rise = st_r.rise;

endmodule // pin_sync

// ===== rtl/timer_pkg.sv
// constants, widths and encodings of the two-half general timer
// assumes a single system clock domain and plain control ports
package timer_pkg;

  // --------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------
  localparam int HALF_W = 16;
  localparam int CNT_W = 32;
  localparam int PRE_W = 8;
  localparam int CFG_W = 3;
  localparam int MODE_W = 2;
  localparam int IRQ_W = 2;
  localparam int DIV_W = 16;

  typedef logic [HALF_W-1:0] half_t;
  typedef logic [CNT_W-1:0] word_t;
  typedef logic [PRE_W-1:0] pre_t;
  typedef logic [CFG_W-1:0] cfg_t;
  typedef logic [MODE_W-1:0] mode_t;
  typedef logic [IRQ_W-1:0] irq_t;
  typedef logic [DIV_W-1:0] div_t;

  // --------------------------------------------------------------------
  // configuration select values
  // --------------------------------------------------------------------
  localparam cfg_t CFG_32_TIMER = 3'h0;
  localparam cfg_t CFG_32_RTC = 3'h1;
  localparam cfg_t CFG_16_SPLIT = 3'h4;
  localparam cfg_t CFG_RESET = 3'h0;

  // --------------------------------------------------------------------
  // first half mode field values
  // --------------------------------------------------------------------
  localparam mode_t MODE_ONE_SHOT = 2'h1;
  localparam mode_t MODE_PERIODIC = 2'h2;
  localparam mode_t MODE_RESET = 2'h0;

  // --------------------------------------------------------------------
  // reset values and counter constants
  // --------------------------------------------------------------------
  localparam half_t HALF_RESET = 16'hffff;
  localparam half_t HALF_ZERO = 16'h0000;
  localparam pre_t PRE_RESET = 8'h00;
  localparam word_t WORD_ZERO = 32'h0000_0000;
  localparam word_t WORD_STEP = 32'h0000_0001;
  localparam word_t RTC_FIRST_LOAD = 32'h0000_0001;
  localparam div_t DIV_ZERO = 16'h0000;
  localparam div_t DIV_STEP = 16'h0001;

  // --------------------------------------------------------------------
  // interrupt status bit positions
  // --------------------------------------------------------------------
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_MATCH_BIT = 1;
  localparam irq_t IRQ_NONE = 2'h0;

  // --------------------------------------------------------------------
  // real-time clock divider
  // --------------------------------------------------------------------
  localparam int RTC_IN_HZ = 32768;
  localparam int RTC_OUT_HZ = 1;
  localparam int RTC_DIV = RTC_IN_HZ / RTC_OUT_HZ;

endpackage

// ===== verif/general_timer_tb.sv
// self-checking bench for the general timer
// assumes rtl package, timer_monitor and rtc_source compiled first
`timescale 1ns/1ps
module general_timer_tb;
  localparam int CFG = 0, MODE = 1, CTL = 2, LOAD = 3, LOAD2 = 4;
  localparam int MATCH = 5, PRE1 = 6, PRE2 = 7, MASK = 8, CLR = 9;
  logic ref_clk, sys_rst, debug_halt, run, capture_pin_0;
  logic [9:0] stb;
  logic [31:0] wd, r, c;
  logic [2:0] config_select;
  logic first_enable_bit, timer_irq, timeout_trigger;
  logic [31:0] first_count_value, first_interval_load;
  logic [15:0] second_count_value, second_interval_load;
  logic [7:0] first_prescale_value, second_prescale_value;
  logic [1:0] raw_irq_status, masked_irq_status;
  int mismatches = 0;
  int checked = 0;
  int n;
  integer seed = 32'h9a4f;
  logic [31:0] model_cnt, model_load;
  logic [2:0] model_cfg;
  logic model_en, model_shot, model_stall, model_clk, model_trig;
  general_timer #(.RTC_DIV(4)) uut (
    .ref_clk, .sys_rst, .capture_pin_0, .debug_halt,
    .cfg_wr(stb[CFG]), .cfg_wdata(wd[2:0]),
    .mode_wr(stb[MODE]), .mode_wdata(wd[1:0]), .ctl_wr(stb[CTL]),
    .ctl_first_enable(wd[0]), .ctl_first_stall(wd[1]),
    .ctl_second_stall(wd[2]), .ctl_clock_mode_enable(wd[3]),
    .load_wr(stb[LOAD]), .load_wdata(wd),
    .second_load_wr(stb[LOAD2]), .second_load_wdata(wd[15:0]),
    .match_wr(stb[MATCH]), .match_wdata(wd),
    .first_prescale_wr(stb[PRE1]), .second_prescale_wr(stb[PRE2]),
    .prescale_wdata(wd[7:0]), .mask_wr(stb[MASK]), .mask_wdata(wd[1:0]),
    .clear_wr(stb[CLR]), .clear_wdata(wd[1:0]), .config_select,
    .first_enable_bit, .first_count_value, .second_count_value,
    .first_interval_load, .second_interval_load, .first_prescale_value,
    .second_prescale_value, .raw_irq_status, .masked_irq_status,
    .timer_irq, .timeout_trigger
  );
  rtc_source src (.run(run), .pin(capture_pin_0));
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input int idx, input logic [31:0] d);
    @(posedge ref_clk);
    stb[idx] <= 1'b1;
    wd <= d;
    @(posedge ref_clk);
    stb <= '0;
    #1;
  endtask
  task automatic wait_trig();
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (timeout_trigger !== 1'b1 && n < 100);
  endtask
  task automatic wait_cnt(input logic [31:0] v);
    n = 0;
    while (first_count_value !== v && n < 4000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // reference model of the joined down-counter, compared every cycle while config is 0
  always @(posedge ref_clk) begin
    model_trig = 1'b0;
    if (sys_rst) begin
      model_cnt = 32'hffffffff;
      model_load = 32'hffffffff;
      model_cfg = 3'h0;
      model_en = 1'b0;
      model_shot = 1'b0;
      model_stall = 1'b0;
      model_clk = 1'b0;
    end else begin
      if (model_cfg == 3'h0 && model_en &&
          !(debug_halt && model_stall && !model_clk)) begin
        if (model_cnt == 32'h0) begin
          model_cnt = model_load;
          model_trig = 1'b1;
          model_en = !model_shot;
        end else begin
          model_cnt = model_cnt - 32'h1;
        end
      end
      if (stb[LOAD]) begin
        model_load = wd;
        model_cnt = wd;
      end
      if (stb[LOAD2]) begin
        model_load[31:16] = wd[15:0];
      end
      if (stb[MODE]) begin
        model_shot = (wd[1:0] == 2'h1);
      end
      if (stb[CTL]) begin
        model_en = wd[0];
        model_stall = wd[1];
        model_clk = wd[3];
      end
      if (stb[CFG]) begin
        model_cfg = wd[2:0];
      end
    end
    #1;
    if (model_cfg == 3'h0) begin
      check("model count", first_count_value, model_cnt);
      check("model trigger", timeout_trigger, model_trig);
      check("model enable", first_enable_bit, model_en);
    end
  end
  initial begin
    #3000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    debug_halt = 1'b0;
    run = 1'b0;
    stb = '0;
    wd = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    check("count", first_count_value, 32'hffffffff);
    check("load", first_interval_load, 32'hffffffff);
    check("count2", second_count_value, 32'hffff);
    check("load2", second_interval_load, 32'hffff);
    check("pre", {first_prescale_value, second_prescale_value}, 0);
    check("cfg", config_select, 3'h0);
    check("status", {first_enable_bit, raw_irq_status}, 3'h0);
    r = $random(seed);
    put(PRE1, r);
    put(PRE2, ~r);
    check("pre", {first_prescale_value, second_prescale_value},
          {r[7:0], ~r[7:0]});
    r = $random(seed);
    put(LOAD, r);
    check("load2", second_interval_load, r[31:16]);
    check("view", first_count_value, r);
    put(LOAD2, 32'h1234);
    check("view", first_interval_load, {16'h1234, r[15:0]});
    put(MASK, 32'h1);
    for (int m = 1; m <= 2; m++) begin
      r = 32'h3 + m;
      put(LOAD, r);
      put(MODE, m);
      put(CTL, 32'h1);
      wait_trig();
      check("period", n, r + 1);
      check("reload", first_count_value, r);
      check("raw", raw_irq_status, 2'h1);
      check("masked", {timer_irq, masked_irq_status}, 3'h5);
      check("enable", first_enable_bit, m == 2);
      put(CLR, 32'h2);
      check("raw", raw_irq_status, 2'h1);
      put(CLR, 32'h1);
      check("raw", raw_irq_status, 2'h0);
    end
    put(LOAD, 32'h20);
    check("rewrite", first_count_value, 32'h20);
    put(CTL, 32'h3);
    @(posedge ref_clk);
    debug_halt <= 1'b1;
    #1;
    c = first_count_value;
    repeat (5) @(posedge ref_clk);
    debug_halt <= 1'b0;
    #1;
    check("frozen", first_count_value, c);
    @(posedge ref_clk);
    #1;
    check("resumed", first_count_value, c - 1);
    put(CTL, 32'h0);
    put(CLR, 32'h3);
    check("raw", raw_irq_status, 2'h0);
    put(MATCH, 32'h2);
    put(MASK, 32'h2);
    put(CFG, 32'h1);
    check("first", first_count_value, 32'h1);
    put(LOAD, 32'h77);
    check("first", first_count_value, 32'h1);
    @(posedge ref_clk);
    debug_halt <= 1'b1;
    put(CTL, 32'hf);
    run = 1'b1;
    wait_cnt(32'h2);
    check("tick", first_count_value, 32'h2);
    wait_cnt(32'h0);
    check("roll", first_count_value, 32'h0);
    check("match", {timer_irq, masked_irq_status, raw_irq_status},
          5'h1a);
    put(CLR, 32'h2);
    check("cleared", {timer_irq, masked_irq_status, raw_irq_status},
          5'h00);
    run = 1'b0;
    @(posedge ref_clk);
    debug_halt <= 1'b0;
    put(CFG, 32'h4);
    c = second_interval_load;
    put(LOAD, 32'habcd1234);
    check("split", first_interval_load, 32'h1234);
    check("split2", second_interval_load, c);
    tally_and_finish();
  end
endmodule // general_timer_tb
bind general_timer timer_monitor mon (
  .ref_clk, .sys_rst, .debug_halt, .cfg_wr, .ctl_wr, .load_wr,
  .second_load_wr, .load_wdata, .clear_wr, .clear_wdata, .config_select,
  .first_enable_bit, .first_count_value, .first_interval_load,
  .raw_irq_status, .masked_irq_status, .timer_irq, .timeout_trigger
);

// ===== verif/rtc_source.sv
// slow clock source on the even capture pin
// assumes the bench raises run only during a clock-mode test
`timescale 1ns/1ps
module rtc_source #(
  parameter int HALF_NS = 15259
) (
  // control
  input wire logic run,
  // pin
  output logic pin
);
  initial begin
    pin = 1'b0;
    forever begin
      #(HALF_NS);
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule // rtc_source

// ===== verif/timer_monitor.sv
// port assertions for the general timer
// assumes a bind from the bench top; one clock domain
`timescale 1ns/1ps
module timer_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // inputs
  input wire logic debug_halt,
  input wire logic cfg_wr,
  input wire logic ctl_wr,
  input wire logic load_wr,
  input wire logic second_load_wr,
  input wire logic [31:0] load_wdata,
  input wire logic clear_wr,
  input wire logic [1:0] clear_wdata,
  // outputs
  input wire logic [2:0] config_select,
  input wire logic first_enable_bit,
  input wire logic [31:0] first_count_value,
  input wire logic [31:0] first_interval_load,
  input wire logic [1:0] raw_irq_status,
  input wire logic [1:0] masked_irq_status,
  input wire logic timer_irq,
  input wire logic timeout_trigger
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  wire logic quiet = !cfg_wr && !ctl_wr && !load_wr;
  sequence s_timer_run;
    config_select == 3'h0 && first_enable_bit && !debug_halt && quiet;
  endsequence
  sequence s_rtc_run;
    config_select == 3'h1 && !cfg_wr;
  endsequence
  a_reset_values: assert property ($fell(sys_rst) |->
    first_count_value == 32'hffffffff && first_interval_load == 32'hffffffff
    && config_select == 3'h0 && raw_irq_status == 2'h0)
    else $error("reset values wrong");
  a_load_both: assert property (config_select == 3'h0 && load_wr &&
    !second_load_wr |=> first_interval_load == $past(load_wdata)
    && first_count_value == $past(load_wdata))
    else $error("load write not taken");
  a_count_down: assert property (s_timer_run ##0
    first_count_value != 32'h0 |=>
    first_count_value == $past(first_count_value) - 32'h1)
    else $error("count did not step down");
  a_zero_reload: assert property (s_timer_run ##0
    first_count_value == 32'h0 |=> timeout_trigger && raw_irq_status[0]
    && first_count_value == $past(first_interval_load))
    else $error("no reload at zero");
  a_trig_cause: assert property (timeout_trigger |->
    raw_irq_status[0] && first_count_value == first_interval_load)
    else $error("trigger without timeout");
  a_raw_sticky: assert property (raw_irq_status[0] &&
    !(clear_wr && clear_wdata[0]) |=> raw_irq_status[0])
    else $error("timeout flag dropped");
  a_irq_level: assert property (timer_irq == |masked_irq_status &&
    (masked_irq_status & ~raw_irq_status) == 2'h0)
    else $error("masked status wrong");
  a_match_clear: assert property (clear_wr && clear_wdata[1] |=>
    (!raw_irq_status[1] && !masked_irq_status[1]) ||
    (config_select == 3'h1 && $changed(first_count_value)))
    else $error("match flag not cleared");
  a_split_hold: assert property (config_select == 3'h4 && quiet &&
    !second_load_wr |=> $stable(first_count_value))
    else $error("split mode counted");
  a_rtc_step: assert property (s_rtc_run ##1
    $changed(first_count_value) |-> first_count_value == 32'h0 ||
    first_count_value == $past(first_count_value) + 32'h1)
    else $error("clock count jumped");
endmodule // timer_monitor
